/* include/bsq_pkg.sv */
/*
  Constants and types for the brake sequencer and signal pin block.
  Assumes a single 250 MHz clock and a 16-bit parameter access port.
*/
package bsq_pkg;

  // Parameter addresses as seen on the parameter port.
  localparam logic [15:0] ADDR_PIN_STATUS = 16'h082a;
  localparam logic [15:0] ADDR_OUT_SET = 16'h0822;
  localparam logic [15:0] ADDR_FUNC_BASE = 16'h0900;
  localparam logic [15:0] ADDR_FUNC_STEP = 16'h0002;
  localparam logic [15:0] ADDR_REL_DLY = 16'h0910;
  localparam logic [15:0] ADDR_ENG_DLY = 16'h0912;

  // Number of configurable signal pins.
  localparam int NUM_PINS = 4;

  // Pin function codes; bit 3 set means the pin is an output.
  typedef logic [3:0] bsq_func_t;
  localparam int FUNC_DIR_BIT = 3;
  localparam bsq_func_t FUNC_FREE_IN = 4'h0;
  localparam bsq_func_t FUNC_POS_END = 4'h1;
  localparam bsq_func_t FUNC_NEG_END = 4'h2;
  localparam bsq_func_t FUNC_HOME_REF = 4'h3;
  localparam bsq_func_t FUNC_OUT_FREE = 4'h8;
  localparam bsq_func_t FUNC_OUT_NOFAULT = 4'h9;
  localparam bsq_func_t FUNC_OUT_ACTIVE = 4'ha;

  // Factory function of each pin after reset.
  localparam bsq_func_t FUNC_PIN1_RST = FUNC_POS_END;
  localparam bsq_func_t FUNC_PIN2_RST = FUNC_NEG_END;
  localparam bsq_func_t FUNC_PIN3_RST = FUNC_FREE_IN;
  localparam bsq_func_t FUNC_PIN4_RST = FUNC_HOME_REF;

  // Reset values of the data registers.
  localparam logic [15:0] PIN_STATUS_RST = 16'h0000;
  localparam logic [3:0] OUT_SET_RST = 4'h0;

  // Delay times in nanoseconds and their cycle counts (rounded up).
  localparam int CLK_PERIOD_NS = 4;
  localparam int REL_DLY_NS = 4000;
  localparam int ENG_DLY_NS = 4000;
  localparam logic [15:0] REL_DLY_RST = 16'((REL_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] ENG_DLY_RST = 16'((ENG_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Operating state numbers shown on the state output.
  localparam logic [3:0] OPST_ENABLED = 4'h6;
  localparam logic [3:0] OPST_SWITCHED_ON = 4'h4;

  // Brake sequencer states.
  typedef enum logic [1:0] {
    BSQ_OFF,
    BSQ_RELEASING,
    BSQ_ENABLED,
    BSQ_ENGAGING
  } bsq_state_e;

endpackage

/* hw/bsq_brake_lio.sv */
/*
  Holding brake sequencer and configurable signal pins with a status word.
  Assumes error and enable inputs come from logic on mclk_i; the pins and
  the torque-off input are asynchronous and are synchronised here.
*/
// Functional notes
// - Brake follows power stage and errors automatically.
// - Enabling the power stage releases the brake.
// - After release delay enter operating state 6.
// - Disable or class 2: brake, delayed current off.
// - Class 3 or 4: brake, current off immediately.
// - Torque-off input removes current without delay.
// - Each pin has its own function select.
// - Pins one, two default to end switches.
// - Pin three free, pin four homing reference.
// - Live pin levels in read-only 16-bit word.
// - Bit 0 is pin one, ascending order.
`timescale 1ns/1ps
module bsq_brake_lio
  import bsq_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic power_enable_i,
  input wire logic error_class2_i,
  input wire logic error_class34_i,
  input wire logic torque_off_safety_input_i,
  input wire logic [3:0] pin_in_i,
  input wire logic [15:0] param_addr_i,
  input wire logic param_wr_i,
  input wire logic param_rd_i,
  input wire logic [15:0] param_wdata_i,
  output logic [15:0] param_rdata_o,
  output logic param_ack_o,
  output logic [3:0] pin_out_o,
  output logic [3:0] pin_oe_n_o,
  output logic brake_release_o,
  output logic motor_current_on_o,
  output logic [3:0] op_state_o,
  output logic positive_end_switch_o,
  output logic negative_end_switch_o,
  output logic home_ref_switch_o
);

  // Tells whether a function code makes the pin an output.
  function automatic logic func_is_out(input bsq_func_t f);
    func_is_out = f[FUNC_DIR_BIT];
  endfunction

  // OR of the levels of all pins carrying the given function.
  function automatic logic pin_with_func(input bsq_func_t fsel [NUM_PINS],
                                         input logic [3:0] lvl,
                                         input bsq_func_t f);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_PINS; i++)
    begin
      if (fsel[i] == f)
      begin
        hit = hit | lvl[i];
      end
    end
    pin_with_func = hit;
  endfunction

  logic [3:0] pin_meta_r;
  logic [3:0] pin_sync_r;
  logic sto_meta_r;
  logic sto_sync_r;
  bsq_func_t func_r [NUM_PINS];
  bsq_func_t func_nxt [NUM_PINS];
  logic [3:0] out_set_r;
  logic [3:0] out_set_nxt;
  logic [15:0] rel_dly_r;
  logic [15:0] rel_dly_nxt;
  logic [15:0] eng_dly_r;
  logic [15:0] eng_dly_nxt;
  logic [15:0] rdata_nxt;
  logic ack_nxt;
  bsq_state_e state_r;
  bsq_state_e state_nxt;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic [3:0] pin_out_nxt;
  logic [3:0] pin_oe_n_nxt;
  logic [15:0] status_nxt;
  logic [15:0] status_r;
  logic hard_stop;
  logic soft_stop;
  logic any_err;

  // Two-stage synchronisers for the pins and the torque-off input.
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      pin_meta_r <= 4'h0;
      pin_sync_r <= 4'h0;
      sto_meta_r <= 1'b0;
      sto_sync_r <= 1'b0;
    end
    else
    begin
      pin_meta_r <= pin_in_i;
      pin_sync_r <= pin_meta_r;
      sto_meta_r <= torque_off_safety_input_i;
      sto_sync_r <= sto_meta_r;
    end
  end

  // Parameter port: writes to settings, reads of status and settings.
  always_comb
  begin
    func_nxt = func_r;
    out_set_nxt = out_set_r;
    rel_dly_nxt = rel_dly_r;
    eng_dly_nxt = eng_dly_r;
    rdata_nxt = param_rdata_o;
    ack_nxt = param_wr_i | param_rd_i;
    if (param_wr_i)
    begin
      for (int i = 0; i < NUM_PINS; i++)
      begin
        if (param_addr_i == ADDR_FUNC_BASE + 16'(i) * ADDR_FUNC_STEP)
        begin
          func_nxt[i] = param_wdata_i[3:0];
        end
      end
      if (param_addr_i == ADDR_OUT_SET)
      begin
        out_set_nxt = param_wdata_i[3:0];
      end
      if (param_addr_i == ADDR_REL_DLY)
      begin
        rel_dly_nxt = param_wdata_i;
      end
      if (param_addr_i == ADDR_ENG_DLY)
      begin
        eng_dly_nxt = param_wdata_i;
      end
    end
    if (param_rd_i)
    begin
      rdata_nxt = 16'h0000;
      if (param_addr_i == ADDR_PIN_STATUS)
      begin
        rdata_nxt = status_r;
      end
      if (param_addr_i == ADDR_OUT_SET)
      begin
        rdata_nxt = {12'h000, out_set_r};
      end
      if (param_addr_i == ADDR_REL_DLY)
      begin
        rdata_nxt = rel_dly_r;
      end
      if (param_addr_i == ADDR_ENG_DLY)
      begin
        rdata_nxt = eng_dly_r;
      end
      for (int i = 0; i < NUM_PINS; i++)
      begin
        if (param_addr_i == ADDR_FUNC_BASE + 16'(i) * ADDR_FUNC_STEP)
        begin
          rdata_nxt = {12'h000, func_r[i]};
        end
      end
    end
  end

  // Settings registers with factory defaults.
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      func_r[0] <= FUNC_PIN1_RST;
      func_r[1] <= FUNC_PIN2_RST;
      func_r[2] <= FUNC_PIN3_RST;
      func_r[3] <= FUNC_PIN4_RST;
      out_set_r <= OUT_SET_RST;
      rel_dly_r <= REL_DLY_RST;
      eng_dly_r <= ENG_DLY_RST;
      param_rdata_o <= 16'h0000;
      param_ack_o <= 1'b0;
    end
    else
    begin
      func_r <= func_nxt;
      out_set_r <= out_set_nxt;
      rel_dly_r <= rel_dly_nxt;
      eng_dly_r <= eng_dly_nxt;
      param_rdata_o <= rdata_nxt;
      param_ack_o <= ack_nxt;
    end
  end

  // Stop classes: hard stops cut current now, soft ones brake first.
  assign any_err = error_class2_i | error_class34_i;
  assign hard_stop = error_class34_i | sto_sync_r;
  assign soft_stop = ~power_enable_i | error_class2_i;

  // Brake sequencer next state and delay counter.
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    unique case (state_r)
      BSQ_OFF:
      begin
        if (power_enable_i && !any_err && !sto_sync_r)
        begin
          state_nxt = BSQ_RELEASING;
          cnt_nxt = rel_dly_r;
        end
      end
      BSQ_RELEASING:
      begin
        if (hard_stop)
        begin
          state_nxt = BSQ_OFF;
        end
        else if (soft_stop)
        begin
          state_nxt = BSQ_ENGAGING;
          cnt_nxt = eng_dly_r;
        end
        else if (cnt_r == 16'h0000)
        begin
          state_nxt = BSQ_ENABLED;
        end
        else
        begin
          cnt_nxt = cnt_r - 16'h0001;
        end
      end
      BSQ_ENABLED:
      begin
        if (hard_stop)
        begin
          state_nxt = BSQ_OFF;
        end
        else if (soft_stop)
        begin
          state_nxt = BSQ_ENGAGING;
          cnt_nxt = eng_dly_r;
        end
      end
      BSQ_ENGAGING:
      begin
        if (hard_stop || cnt_r == 16'h0000)
        begin
          state_nxt = BSQ_OFF;
        end
        else
        begin
          cnt_nxt = cnt_r - 16'h0001;
        end
      end
    endcase
  end

  // Brake sequencer registers and its registered outputs.
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      state_r <= BSQ_OFF;
      cnt_r <= 16'h0000;
      brake_release_o <= 1'b0;
      motor_current_on_o <= 1'b0;
      op_state_o <= OPST_SWITCHED_ON;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      brake_release_o <= (state_nxt == BSQ_RELEASING) || (state_nxt == BSQ_ENABLED);
      motor_current_on_o <= state_nxt != BSQ_OFF;
      op_state_o <= (state_nxt == BSQ_ENABLED) ? OPST_ENABLED : OPST_SWITCHED_ON;
    end
  end

  // Pin drive, direction and the live level status word.
  always_comb
  begin
    status_nxt = PIN_STATUS_RST;
    for (int i = 0; i < NUM_PINS; i++)
    begin
      pin_oe_n_nxt[i] = ~func_is_out(func_r[i]);
      unique case (func_r[i])
        FUNC_OUT_FREE: pin_out_nxt[i] = out_set_r[i];
        FUNC_OUT_NOFAULT: pin_out_nxt[i] = ~any_err;
        FUNC_OUT_ACTIVE: pin_out_nxt[i] = state_r == BSQ_ENABLED;
        default: pin_out_nxt[i] = 1'b0;
      endcase
      status_nxt[i] = func_is_out(func_r[i]) ? pin_out_o[i] : pin_sync_r[i];
    end
  end

  // Pin registers and decoded switch inputs.
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      pin_out_o <= 4'h0;
      pin_oe_n_o <= 4'hf;
      status_r <= PIN_STATUS_RST;
      positive_end_switch_o <= 1'b0;
      negative_end_switch_o <= 1'b0;
      home_ref_switch_o <= 1'b0;
    end
    else
    begin
      pin_out_o <= pin_out_nxt;
      pin_oe_n_o <= pin_oe_n_nxt;
      status_r <= status_nxt;
      positive_end_switch_o <= pin_with_func(func_r, pin_sync_r, FUNC_POS_END);
      negative_end_switch_o <= pin_with_func(func_r, pin_sync_r, FUNC_NEG_END);
      home_ref_switch_o <= pin_with_func(func_r, pin_sync_r, FUNC_HOME_REF);
    end
  end

  // Checks on the sequencer and pin logic.
  sequence s_enable_start;
    state_r == BSQ_OFF && power_enable_i && !any_err && !sto_sync_r;
  endsequence

  sequence s_soft_from_on;
    (state_r == BSQ_ENABLED) && !hard_stop && soft_stop;
  endsequence

  a_release_on_enable: assert property (@(posedge mclk_i) disable iff (reset_i)
    s_enable_start |=> brake_release_o && motor_current_on_o)
    else $error("brake not released after enable");

  a_state6_after_delay: assert property (@(posedge mclk_i) disable iff (reset_i)
    $rose(op_state_o == OPST_ENABLED) |-> $past(state_r) == BSQ_RELEASING && $past(cnt_r) == 0)
    else $error("state 6 reached before delay expired");

  a_brake_first: assert property (@(posedge mclk_i) disable iff (reset_i)
    s_soft_from_on |=> !brake_release_o && motor_current_on_o && cnt_r == $past(eng_dly_r))
    else $error("soft stop did not brake with current kept");

  a_hard_stop_cut: assert property (@(posedge mclk_i) disable iff (reset_i)
    error_class34_i |=> !motor_current_on_o && !brake_release_o)
    else $error("class 3 or 4 error left current on");

  a_sto_cut: assert property (@(posedge mclk_i) disable iff (reset_i)
    sto_sync_r |=> !motor_current_on_o)
    else $error("torque-off left current on");

  a_brake_auto: assert property (@(posedge mclk_i) disable iff (reset_i)
    brake_release_o |-> motor_current_on_o)
    else $error("brake released without motor current");

  a_func_dir: assert property (@(posedge mclk_i) disable iff (reset_i)
    ##1 pin_oe_n_o == ~{func_is_out($past(func_r[3])), func_is_out($past(func_r[2])),
                        func_is_out($past(func_r[1])), func_is_out($past(func_r[0]))})
    else $error("pin direction does not follow function select");

  a_factory_defaults: assert property (@(posedge mclk_i)
    $fell(reset_i) |-> func_r[0] == FUNC_POS_END && func_r[1] == FUNC_NEG_END)
    else $error("pins one or two not end switches after reset");

  a_factory_others: assert property (@(posedge mclk_i)
    $fell(reset_i) |-> func_r[2] == FUNC_FREE_IN && func_r[3] == FUNC_HOME_REF)
    else $error("pins three or four wrong after reset");

  a_status_input: assert property (@(posedge mclk_i) disable iff (reset_i)
    !func_is_out(func_r[0]) ##1 1'b1 |-> status_r[0] == $past(pin_sync_r[0]))
    else $error("status bit 0 not live pin one level");

  a_status_order: assert property (@(posedge mclk_i) disable iff (reset_i)
    param_rd_i && param_addr_i == ADDR_PIN_STATUS |=>
      param_rdata_o[15:4] == 12'h000 && param_rdata_o[3:0] == $past(status_r[3:0]))
    else $error("status word bit order wrong");

  a_engage_count: assert property (@(posedge mclk_i) disable iff (reset_i)
    state_r == BSQ_ENGAGING && !hard_stop && cnt_r != 0 |=> cnt_r == $past(cnt_r) - 16'h0001)
    else $error("disconnect delay counter did not count down");

endmodule

/* tb/bsq_partner.sv */
/*
  Far-side model: the holding brake with its load, the power stage
  current sense and the four signal pin wires.
  Assumes the bench sets the external pin levels on pin_ext_i.
*/
`timescale 1ns/1ps
module bsq_partner
  import bsq_pkg::*;
(
  input wire logic mclk_i,
  input wire logic [3:0] pin_ext_i,
  input wire logic [3:0] pin_out_i,
  input wire logic [3:0] pin_oe_n_i,
  input wire logic brake_release_i,
  input wire logic motor_current_on_i,
  output logic [3:0] pin_lvl_o,
  output logic load_drop_o
);
  logic cur_q;

  // A driven pin shows the drive, an undriven one the external switch.
  always_comb
  begin
    for (int i = 0; i < NUM_PINS; i++)
      pin_lvl_o[i] = pin_oe_n_i[i] ? pin_ext_i[i] : pin_out_i[i];
  end

  // The load drops if torque goes while the brake is still open.
  // One process owns the drop flag so that it has a single driver.
  initial
  begin
    load_drop_o = 1'b0;
    cur_q = 1'b0;
    forever
    begin
      @(posedge mclk_i);
      cur_q <= motor_current_on_i;
      if (cur_q && !motor_current_on_i && brake_release_i)
        load_drop_o <= 1'b1;
    end
  end
endmodule

/* tb/tb.sv */
/*
  Testbench for the brake sequencer and signal pin block.
  Assumes the package constants and the parameter port contract.
*/
`timescale 1ns/1ps
module tb;
  import bsq_pkg::*;
  logic mclk_i, reset_i, power_enable_i, error_class2_i, error_class34_i;
  logic torque_off_safety_input_i, param_wr_i, param_rd_i, param_ack_o;
  logic brake_release_o, motor_current_on_o, load_drop;
  logic positive_end_switch_o, negative_end_switch_o, home_ref_switch_o;
  logic [3:0] pin_ext, pin_lvl, pin_out_o, pin_oe_n_o, op_state_o;
  logic [15:0] param_addr_i, param_wdata_i, param_rdata_o, q;
  int err_total = 0;
  int total_checks = 0;
  int n;

  bsq_brake_lio DUT (.mclk_i(mclk_i), .reset_i(reset_i), .power_enable_i(power_enable_i),
    .error_class2_i(error_class2_i), .error_class34_i(error_class34_i),
    .torque_off_safety_input_i(torque_off_safety_input_i), .pin_in_i(pin_lvl),
    .param_addr_i(param_addr_i), .param_wr_i(param_wr_i), .param_rd_i(param_rd_i),
    .param_wdata_i(param_wdata_i), .param_rdata_o(param_rdata_o), .param_ack_o(param_ack_o),
    .pin_out_o(pin_out_o), .pin_oe_n_o(pin_oe_n_o), .brake_release_o(brake_release_o),
    .motor_current_on_o(motor_current_on_o), .op_state_o(op_state_o),
    .positive_end_switch_o(positive_end_switch_o),
    .negative_end_switch_o(negative_end_switch_o), .home_ref_switch_o(home_ref_switch_o));

  bsq_partner far (.mclk_i(mclk_i), .pin_ext_i(pin_ext), .pin_out_i(pin_out_o),
    .pin_oe_n_i(pin_oe_n_o), .brake_release_i(brake_release_o),
    .motor_current_on_i(motor_current_on_o), .pin_lvl_o(pin_lvl), .load_drop_o(load_drop));

  // Free-running 4 ns clock.
  initial
  begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge mclk_i);
    #1;
  endtask

  // One parameter access: strobe for one edge, then wait for the ack pulse.
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d);
    int m;
    @(posedge mclk_i);
    param_addr_i <= a;
    param_wdata_i <= d;
    param_wr_i <= w;
    param_rd_i <= ~w;
    @(posedge mclk_i);
    param_wr_i <= 1'b0;
    param_rd_i <= 1'b0;
    #1;
    m = 0;
    while (param_ack_o !== 1'b1 && m < 4)
    begin
      step(1);
      m++;
    end
    chk(16'(param_ack_o), 16'h0001, "ack");
    q = param_rdata_o;
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    acc(1'b0, a, 16'h0000);
    chk(q, exp, "read");
  endtask

  function automatic logic sig(input int sel);
    case (sel)
      0: return brake_release_o;
      1: return motor_current_on_o;
      default: return op_state_o == OPST_ENABLED;
    endcase
  endfunction

  // Counts cycles until the selected output reaches the wanted level.
  task automatic wt(input int sel, input logic v, output int c);
    c = 0;
    while (sig(sel) !== v && c < 20)
    begin
      step(1);
      c++;
    end
  endtask

  // Enable and measure the release-to-enabled delay of 2 + 1 cycles.
  task automatic go_on();
    @(posedge mclk_i);
    power_enable_i <= 1'b1;
    step(1);
    wt(0, 1'b1, n);
    chk(16'(n <= 2), 16'h0001, "release late");
    chk(16'(motor_current_on_o), 16'h0001, "current on");
    wt(2, 1'b1, n);
    chk(16'(n), 16'h0003, "enable delay");
    step(1);
    chk(16'(pin_out_o[3]), 16'h0001, "active output");
  endtask

  // Stop causes: 0 disable, 1 class 2, 2 class 3/4, 3 torque-off.
  task automatic stop(input int k);
    @(posedge mclk_i);
    case (k)
      0: power_enable_i <= 1'b0;
      1: error_class2_i <= 1'b1;
      2: error_class34_i <= 1'b1;
      default: torque_off_safety_input_i <= 1'b1;
    endcase
    step(1);
    chk(16'(pin_out_o[2]), 16'(k == 0 || k == 3), "no-fault output");
    wt(0, 1'b0, n);
    chk(16'(n <= (k == 3 ? 3 : 1)), 16'h0001, "brake late");
    if (k < 2)
    begin
      chk(16'(motor_current_on_o), 16'h0001, "current held");
      chk(16'(op_state_o), 16'(OPST_SWITCHED_ON), "left state 6");
      wt(1, 1'b0, n);
      chk(16'(n), 16'h0003, "disconnect delay");
    end
    else
      chk(16'(motor_current_on_o), 16'h0000, "current cut");
    @(posedge mclk_i);
    power_enable_i <= 1'b0;
    error_class2_i <= 1'b0;
    error_class34_i <= 1'b0;
    torque_off_safety_input_i <= 1'b0;
    step(8);
    $display("test stop cause %0d done", k);
  endtask

  // Cuts the run short if the tests hang.
  initial
  begin
    repeat (20000) @(posedge mclk_i);
    err_total++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_sim();
  end

  // Main test sequence.
  initial
  begin
    {power_enable_i, error_class2_i, error_class34_i, torque_off_safety_input_i} = 4'h0;
    {param_wr_i, param_rd_i} = 2'b00;
    param_addr_i = 16'h0000;
    param_wdata_i = 16'h0000;
    pin_ext = 4'h0;
    reset_i = 1'b1;
    repeat (16) @(posedge mclk_i);
    reset_i <= 1'b0;
    rd(ADDR_PIN_STATUS, PIN_STATUS_RST);
    rd(ADDR_FUNC_BASE, 16'(FUNC_PIN1_RST));
    rd(ADDR_FUNC_BASE + ADDR_FUNC_STEP, 16'(FUNC_PIN2_RST));
    rd(ADDR_FUNC_BASE + 16'h0004, 16'(FUNC_PIN3_RST));
    rd(ADDR_FUNC_BASE + 16'h0006, 16'(FUNC_PIN4_RST));
    rd(ADDR_REL_DLY, REL_DLY_RST);
    acc(1'b1, ADDR_PIN_STATUS, 16'hffff);
    rd(ADDR_PIN_STATUS, 16'h0000);
    rd(16'h0100, 16'h0000);
    acc(1'b1, ADDR_REL_DLY, 16'h0002);
    acc(1'b1, ADDR_ENG_DLY, 16'h0002);
    rd(ADDR_ENG_DLY, 16'h0002);
    @(posedge mclk_i);
    pin_ext <= 4'b1001;
    step(4);
    rd(ADDR_PIN_STATUS, 16'h0009);
    chk(16'({positive_end_switch_o, negative_end_switch_o, home_ref_switch_o}), 16'h0005,
      "switch inputs");
    acc(1'b1, ADDR_FUNC_BASE + ADDR_FUNC_STEP, 16'(FUNC_OUT_FREE));
    acc(1'b1, ADDR_OUT_SET, 16'h0002);
    step(4);
    chk(16'({pin_oe_n_o, pin_out_o[1]}), 16'h001b, "pin two drive");
    rd(ADDR_PIN_STATUS, 16'h000b);
    acc(1'b1, ADDR_FUNC_BASE + 16'h0004, 16'(FUNC_OUT_NOFAULT));
    acc(1'b1, ADDR_FUNC_BASE + 16'h0006, 16'(FUNC_OUT_ACTIVE));
    step(2);
    chk(16'(pin_out_o[3:2]), 16'h0001, "no-fault and active outputs");
    rd(ADDR_PIN_STATUS, 16'h0007);
    $display("test registers and pins done");
    @(posedge mclk_i);
    error_class2_i <= 1'b1;
    power_enable_i <= 1'b1;
    step(6);
    chk(16'(brake_release_o), 16'h0000, "enable refused");
    @(posedge mclk_i);
    error_class2_i <= 1'b0;
    power_enable_i <= 1'b0;
    step(4);
    $display("test enable refused done");
    for (int k = 0; k < 4; k++)
    begin
      go_on();
      stop(k);
    end
    chk(16'(load_drop), 16'h0000, "load dropped");
    end_sim();
  end
endmodule
